// *** design/spc_top.sv ***
// Summary of operation
// R1: one byte equals eight clocks, full duplex
// R2: master drives clock pin, slave receives it
// R3: enabled module owns clock pin direction
// R4: CPHA0 master toggles select between bytes
// R5: CPHA1 master may hold select low
// R6: slave select high: tristate MISO, abort
// R7: slave mode: select always module input
// R8: select function follows enable, master, fault-enable
// R9: receive interrupt enable gates receive-full
// R10: master select bit, reset to one
// R11: CPOL sets idle clock level, reset zero
// R12: CPHA sets clock-data timing, reset one
// R13: both ends use identical CPOL, CPHA
// R14: wired-OR bit selects open-drain outputs
// R15: enable bit; clearing performs partial reset
// R16: transmit interrupt enable gates transmit-empty
// R17: receive-full set on transfer, cleared by sequence
// R18: error enable gates overflow and fault
// R19: overflow keeps buffered byte, drops new
// R20: overflow cleared by status then data read
// R21: fault on slave select rise, master low
// R22: fault cleared by status read, control write
// R23: transmit-empty sets on load, clears on write
// R24: rate bits divide 2,8,32,128 in master
// R25: fault enable gates setting, not clearing
// R26: master starts clocking when shifter loaded
`timescale 1ns/1ps
`default_nettype none
module spc_top (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic [3:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [3:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        sck_i,
	output logic             sck_o,
	output logic             sck_oe,
	input  wire logic        mosi_i,
	output logic             mosi_o,
	output logic             mosi_oe,
	input  wire logic        miso_i,
	output logic             miso_o,
	output logic             miso_oe,
	input  wire logic        ss_n_i,
	output logic             pullup_en,
	output logic             ss_gpio,
	output logic             rx_irq,
	output logic             tx_irq
);
	logic [7:0] ctrl_reg;
	logic [3:0] stat_ctl_reg;
	logic       rx_full_reg, ovr_reg, mode_fault_flag_reg, tx_empty_reg;
	logic       rx_armed_reg, mode_fault_flag_armed_reg;
	logic [7:0] tx_buf_reg, rx_buf_reg, shift_reg;
	logic       tx_pend_reg, busy_reg;
	logic [3:0] edge_cnt_reg;
	logic [6:0] div_cnt_reg;
	logic       sck_int_reg;
	logic       mosi_s1, mosi_s2, sck_s1, sck_s2, ss_s1, ss_s2;
	logic       sck_d_reg, ss_d_reg, in_bit_reg;

	// Control field decode
	logic en, mstr, cpol, cpha, wom, mode_fault_enable;
	assign en     = ctrl_reg[spc_pkg::CTRL_EN_BIT];
	assign mstr   = ctrl_reg[spc_pkg::CTRL_MSTR_BIT];
	assign cpol   = ctrl_reg[spc_pkg::CTRL_CPOL_BIT];
	assign cpha   = ctrl_reg[spc_pkg::CTRL_CPHA_BIT];
	assign wom    = ctrl_reg[spc_pkg::CTRL_WOM_BIT];
	assign mode_fault_enable = stat_ctl_reg[spc_pkg::STAT_MODE_FAULT_ENABLE_BIT];

	// Two-flop synchronisers on the far-clocked pins; master input is paced by our own clock
	// and is read directly, otherwise the divide-by-2 rate would sample a stale bit
	always_ff @(posedge clk) begin
		mosi_s1 <= mosi_i;
		mosi_s2 <= mosi_s1;
		sck_s1  <= sck_i;
		sck_s2  <= sck_s1;
		ss_s1   <= ss_n_i;
		ss_s2   <= ss_s1;
	end

	// Edge history of synchronised clock and select
	always_ff @(posedge clk) begin
		if (rst) begin
			sck_d_reg <= 1'b0;
			ss_d_reg  <= 1'b1;
		end else begin
			sck_d_reg <= sck_s2;
			ss_d_reg  <= ss_s2;
		end
	end

	// AXI4-Lite write: take address and data in either order
	logic       aw_held, w_held;
	logic [3:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic       wr_fire, wr_ok;
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready  = !w_held && !s_axi_bvalid;
	assign wr_fire = aw_held && w_held && !s_axi_bvalid;
	assign wr_ok   = aw_addr != spc_pkg::PORT_ADDR;
	always_ff @(posedge clk) begin
		if (rst) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 4'h0;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= spc_pkg::RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? spc_pkg::RESP_OKAY : spc_pkg::RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Write strobes decoded per register, byte lane zero only
	logic wr_ctrl, wr_stat, wr_data;
	assign wr_ctrl = wr_fire && aw_addr == spc_pkg::CTRL_ADDR && w_strb[0];
	assign wr_stat = wr_fire && aw_addr == spc_pkg::STAT_ADDR && w_strb[0];
	assign wr_data = wr_fire && aw_addr == spc_pkg::DATA_ADDR && w_strb[0];

	// AXI4-Lite read, one-cycle answer
	logic rd_stat, rd_data;
	logic [7:0] stat_view;
	assign s_axi_arready = !s_axi_rvalid;
	assign stat_view = {rx_full_reg, stat_ctl_reg[3], ovr_reg, mode_fault_flag_reg, tx_empty_reg, mode_fault_enable, stat_ctl_reg[1:0]};
	assign rd_stat = s_axi_arvalid && s_axi_arready && s_axi_araddr == spc_pkg::STAT_ADDR;
	assign rd_data = s_axi_arvalid && s_axi_arready && s_axi_araddr == spc_pkg::DATA_ADDR;
	always_ff @(posedge clk) begin
		if (rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= spc_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= spc_pkg::RESP_OKAY;
			case (s_axi_araddr)
				spc_pkg::CTRL_ADDR: s_axi_rdata <= {24'h00_0000, ctrl_reg};
				spc_pkg::STAT_ADDR: s_axi_rdata <= {24'h00_0000, stat_view};
				spc_pkg::DATA_ADDR: s_axi_rdata <= {24'h00_0000, rx_buf_reg};
				spc_pkg::PORT_ADDR: s_axi_rdata <= {31'h0000_0000, ss_s2};
				default: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= spc_pkg::RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Slave select role per configuration
	logic ss_used, slave_sel, master_fault_ev, slave_fault_ev;
	assign ss_used = en && (!mstr || mode_fault_enable); // R7 R8
	assign ss_gpio = !ss_used; // R8
	assign slave_sel = en && !mstr && !ss_s2;
	assign master_fault_ev = en && mstr && mode_fault_enable && !ss_s2; // R21
	assign slave_fault_ev = en && !mstr && mode_fault_enable && busy_reg && ss_s2 && !ss_d_reg; // R21

	// Control registers; a master fault drops enable and master
	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl_reg <= spc_pkg::CTRL_RESET; // R9 R10 R11 R12 R15 R16
			stat_ctl_reg <= spc_pkg::STAT_CTL_RESET; // R18
		end else begin
			if (wr_ctrl)
				ctrl_reg <= w_data[7:0];
			if (wr_stat)
				stat_ctl_reg <= {w_data[spc_pkg::STAT_ERROR_INTERRUPT_ENABLE_BIT], w_data[spc_pkg::STAT_MODE_FAULT_ENABLE_BIT], w_data[1:0]};
			if (master_fault_ev) begin
				ctrl_reg[spc_pkg::CTRL_EN_BIT] <= 1'b0;
				ctrl_reg[spc_pkg::CTRL_MSTR_BIT] <= 1'b0;
			end
		end
	end

	// Serial engine strobes
	logic fault_any, sample_ev, shift_ev, byte_done, load_ev;
	logic [6:0] half_cnt;
	logic tick, s_lead, s_trail;
	always_comb begin
		case (stat_ctl_reg[1:0])
			2'b00: half_cnt = spc_pkg::HALF_DIV0; // R24
			2'b01: half_cnt = spc_pkg::HALF_DIV1;
			2'b10: half_cnt = spc_pkg::HALF_DIV2;
			default: half_cnt = spc_pkg::HALF_DIV3;
		endcase
	end
	assign tick = mstr && busy_reg && div_cnt_reg == half_cnt - 7'h01;
	// Slave edges relative to idle polarity
	assign s_lead  = slave_sel && (sck_s2 ^ cpol) && !(sck_d_reg ^ cpol);
	assign s_trail = slave_sel && !(sck_s2 ^ cpol) && (sck_d_reg ^ cpol);
	// Even edge counts are leading edges (count starts at 0)
	assign sample_ev = mstr ? (tick && (edge_cnt_reg[0] == cpha)) : (busy_reg && (cpha ? s_trail : s_lead));
	// Phase 1: first leading edge only presents the loaded MSB, no shift yet
	assign shift_ev  = mstr ? (tick && (edge_cnt_reg[0] != cpha) && !(cpha && edge_cnt_reg == 4'h0)) :
		(busy_reg && (cpha ? (s_lead && edge_cnt_reg != 4'h0) : s_trail)); // R1
	assign byte_done = mstr ? (tick && edge_cnt_reg == 4'hF) : (busy_reg && edge_cnt_reg == 4'hF &&
		(s_lead || s_trail));
	assign fault_any = !en || (!mstr && ss_s2);
	// Load into an idle shifter; slave with CPHA0 loads on select fall
	assign load_ev = en && !busy_reg && tx_pend_reg && (mstr || (!ss_s2 && (cpha || ss_d_reg))); // R26 R4 R5

	// Shift engine: eight clocks per byte
	always_ff @(posedge clk) begin
		if (rst || fault_any) begin // R15 R6
			busy_reg <= 1'b0;
			shift_reg <= 8'h00;
			edge_cnt_reg <= 4'h0;
			div_cnt_reg <= 7'h00;
			sck_int_reg <= 1'b0;
			in_bit_reg <= 1'b0;
		end else if (load_ev) begin
			busy_reg <= 1'b1; // R26
			shift_reg <= tx_buf_reg;
			edge_cnt_reg <= 4'h0;
			div_cnt_reg <= 7'h00;
		end else if (busy_reg) begin
			if (mstr)
				div_cnt_reg <= tick ? 7'h00 : div_cnt_reg + 7'h01;
			if (tick)
				sck_int_reg <= !sck_int_reg; // R2
			if (tick || s_lead || s_trail)
				edge_cnt_reg <= edge_cnt_reg + 4'h1; // R1
			if (sample_ev)
				in_bit_reg <= mstr ? miso_i : mosi_s2;
			if (shift_ev)
				shift_reg <= {shift_reg[6:0], in_bit_reg};
			if (byte_done)
				busy_reg <= 1'b0;
		end
	end

	// Completed byte is the shifter plus the last sampled bit
	logic [7:0] done_byte;
	assign done_byte = {shift_reg[6:0], sample_ev ? (mstr ? miso_i : mosi_s2) : in_bit_reg};

	// Transmit buffer and empty flag
	always_ff @(posedge clk) begin
		if (rst) begin
			tx_buf_reg <= 8'h00;
			tx_pend_reg <= 1'b0;
			tx_empty_reg <= 1'b1;
		end else if (!en) begin
			tx_pend_reg <= 1'b0;
			tx_empty_reg <= 1'b1; // R15
			if (wr_data)
				tx_buf_reg <= w_data[7:0];
		end else if (wr_data) begin
			tx_buf_reg <= w_data[7:0];
			tx_pend_reg <= 1'b1;
			tx_empty_reg <= 1'b0; // R23
		end else if (load_ev) begin
			tx_pend_reg <= 1'b0;
			tx_empty_reg <= 1'b1; // R23
		end
	end

	// Receive buffer, full and overflow flags; set beats clear
	always_ff @(posedge clk) begin
		if (rst) begin
			rx_buf_reg <= 8'h00;
			rx_full_reg <= 1'b0;
			ovr_reg <= 1'b0;
			rx_armed_reg <= 1'b0;
		end else begin
			if (rd_stat)
				rx_armed_reg <= rx_full_reg || ovr_reg;
			if (byte_done && rx_full_reg) begin
				ovr_reg <= 1'b1; // R19
			end else if (byte_done) begin
				rx_buf_reg <= done_byte;
				rx_full_reg <= 1'b1; // R17
			end
			if (rd_data && rx_armed_reg) begin
				rx_armed_reg <= 1'b0;
				if (!byte_done) begin
					rx_full_reg <= 1'b0; // R17
					ovr_reg <= 1'b0; // R20
				end
			end
		end
	end

	// Mode fault flag, cleared by status read then control write
	always_ff @(posedge clk) begin
		if (rst) begin
			mode_fault_flag_reg <= 1'b0;
			mode_fault_flag_armed_reg <= 1'b0;
		end else if (master_fault_ev || slave_fault_ev) begin
			mode_fault_flag_reg <= 1'b1; // R21 R25
			mode_fault_flag_armed_reg <= 1'b0;
		end else begin
			if (rd_stat)
				mode_fault_flag_armed_reg <= mode_fault_flag_reg;
			if (wr_ctrl && mode_fault_flag_armed_reg) begin
				mode_fault_flag_reg <= 1'b0; // R22
				mode_fault_flag_armed_reg <= 1'b0;
			end
		end
	end

	// Pin drive; wired-OR drives only low
	logic sck_val, mosi_val, miso_val;
	assign sck_val  = busy_reg ? (sck_int_reg ^ cpol) : cpol; // R11
	assign mosi_val = shift_reg[7];
	assign miso_val = shift_reg[7];
	assign sck_o  = wom ? 1'b0 : sck_val; // R14
	assign mosi_o = wom ? 1'b0 : mosi_val;
	assign miso_o = wom ? 1'b0 : miso_val;
	assign sck_oe  = en && mstr && (!wom || !sck_val); // R2 R3 R14
	assign mosi_oe = en && mstr && (!wom || !mosi_val);
	assign miso_oe = slave_sel && (!wom || !miso_val); // R6
	assign pullup_en = !wom; // R14

	// Interrupt request levels
	assign rx_irq = (ctrl_reg[spc_pkg::CTRL_RIE_BIT] && rx_full_reg) ||
		(stat_ctl_reg[3] && (ovr_reg || mode_fault_flag_reg)); // R9 R18
	assign tx_irq = ctrl_reg[spc_pkg::CTRL_TIE_BIT] && en && tx_empty_reg; // R16

	// Flag and mode checks
	overflow_keep_a: assert property (@(posedge clk) disable iff (rst)
		byte_done && rx_full_reg |=> ovr_reg && rx_buf_reg == $past(rx_buf_reg)) else $error("overflow lost buffer"); // R19
	rx_full_set_a: assert property (@(posedge clk) disable iff (rst)
		byte_done && !rx_full_reg |=> rx_full_reg) else $error("receive full not set"); // R17
	mode_fault_flag_master_a: assert property (@(posedge clk) disable iff (rst)
		master_fault_ev |=> mode_fault_flag_reg && !en) else $error("master fault missed"); // R21
	mode_fault_flag_hold_a: assert property (@(posedge clk) disable iff (rst)
		mode_fault_flag_reg && !wr_ctrl |=> mode_fault_flag_reg) else $error("fault flag cleared early"); // R22 R25
	tx_empty_load_a: assert property (@(posedge clk) disable iff (rst)
		load_ev && !wr_data |=> tx_empty_reg && busy_reg) else $error("load did not set empty"); // R23 R26
	slave_tristate_a: assert property (@(posedge clk) disable iff (rst)
		!mstr && ss_s2 |-> !miso_oe) else $error("MISO driven while deselected"); // R6
	disable_reset_a: assert property (@(posedge clk) disable iff (rst)
		!en |=> !busy_reg && tx_empty_reg) else $error("partial reset failed"); // R15
	clk_idle_a: assert property (@(posedge clk) disable iff (rst)
		en && mstr && !busy_reg && !wom |-> sck_oe && sck_o == cpol) else $error("idle clock level"); // R11 R2
endmodule : spc_top
`default_nettype wire

// *** include/spc_pkg.sv ***
package spc_pkg;
	// Register byte addresses on the bus
	localparam logic [3:0] CTRL_ADDR   = 4'h0;
	localparam logic [3:0] STAT_ADDR   = 4'h4;
	localparam logic [3:0] DATA_ADDR   = 4'h8;
	localparam logic [3:0] PORT_ADDR   = 4'hC;
	// Control register field positions
	localparam int CTRL_RIE_BIT   = 7;
	localparam int CTRL_MSTR_BIT  = 5;
	localparam int CTRL_CPOL_BIT  = 4;
	localparam int CTRL_CPHA_BIT  = 3;
	localparam int CTRL_WOM_BIT   = 2;
	localparam int CTRL_EN_BIT    = 1;
	localparam int CTRL_TIE_BIT   = 0;
	localparam logic [7:0] CTRL_RESET = 8'h28;
	// Status/control register field positions
	localparam int STAT_RF_BIT    = 7;
	localparam int STAT_ERROR_INTERRUPT_ENABLE_BIT = 6;
	localparam int STAT_OVR_BIT   = 5;
	localparam int STAT_MODE_FAULT_FLAG_BIT  = 4;
	localparam int STAT_TE_BIT    = 3;
	localparam int STAT_MODE_FAULT_ENABLE_BIT = 2;
	localparam logic [3:0] STAT_CTL_RESET = 4'h0;
	// Bits per transfer
	localparam int BYTE_BITS = 8;
	// Half-period counts (bus cycles) for divisors 2, 8, 32, 128
	localparam logic [6:0] HALF_DIV0 = 7'h01;
	localparam logic [6:0] HALF_DIV1 = 7'h04;
	localparam logic [6:0] HALF_DIV2 = 7'h10;
	localparam logic [6:0] HALF_DIV3 = 7'h40;
	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : spc_pkg

// *** test/spc_remote.sv ***
`timescale 1ns/1ps
`default_nettype none
// Far-side slave; inverts its data line when deselected
module spc_remote (
	input  wire logic       sck,
	input  wire logic       mosi,
	input  wire logic       ss_n,
	input  wire logic       cpol,
	input  wire logic       cpha,
	input  wire logic [7:0] tx_byte,
	output logic            miso,
	output logic [7:0]      rx_byte
);
	logic [7:0] sh;
	int         n;
	// Select fall starts a byte; phase 0 shows its first bit early
	always @(negedge ss_n) begin
		n = 0;
		sh = tx_byte;
		if (!cpha) begin
			miso = sh[7];
			sh = sh << 1;
		end
	end
	// Inverse on release, so a stale bit cannot pass for data
	always @(posedge ss_n) miso = ~miso;
	// Sample on one edge, shift on the other, set like the block
	always @(sck) begin
		if (!ss_n && ((sck ^ cpol) ^ cpha)) begin
			rx_byte = {rx_byte[6:0], mosi};
			n = (n == 7) ? 0 : n + 1;
		end else if (!ss_n && (cpha || n != 0)) begin
			if (cpha && n == 0) sh = tx_byte;
			miso = sh[7];
			sh = sh << 1;
		end
	end
	initial miso = 1'b1;
endmodule : spc_remote
`default_nettype wire

// *** test/spc_top_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
// Register rows first, then master, overflow, fault and slave cases
module spc_top_bench;
	typedef struct packed {logic w; logic [3:0] a; logic [7:0] d; logic [7:0] e; logic [1:0] r;} spc_row_t;
	localparam logic [3:0] ca = spc_pkg::CTRL_ADDR;
	localparam logic [3:0] sa = spc_pkg::STAT_ADDR;
	localparam logic [3:0] da = spc_pkg::DATA_ADDR;
	localparam logic [3:0] pa = spc_pkg::PORT_ADDR;
	logic        clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
	logic        sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, ss_n_i, pullup_en, ss_gpio, rx_irq, tx_irq;
	logic        bm_sck, bm_mosi, rm_miso, rs_n;
	logic [7:0]  rm_tx, rm_rx, q;
	int          failures, checked, ne, hi, i;
	// Pin levels from whoever drives
	wire         sck_i = sck_oe ? sck_o : bm_sck;
	wire         mosi_i = mosi_oe ? mosi_o : bm_mosi;
	wire         miso_i = miso_oe ? miso_o : rm_miso;
	spc_row_t rows [10] = '{'{1'b0, ca, 8'h00, 8'h28, 2'h0}, '{1'b0, sa, 8'h00, 8'h08, 2'h0},
		'{1'b1, ca, 8'h9C, 8'h00, 2'h0}, '{1'b0, ca, 8'h00, 8'h9C, 2'h0}, '{1'b1, sa, 8'h47, 8'h00, 2'h0},
		'{1'b0, sa, 8'h00, 8'h4F, 2'h0}, '{1'b1, sa, 8'h00, 8'h00, 2'h0}, '{1'b1, pa, 8'h00, 8'h00, 2'h2},
		'{1'b0, pa, 8'h00, 8'h01, 2'h0}, '{1'b1, ca, 8'h00, 8'h00, 2'h0}};
	spc_top dut (.*);
	spc_remote rem (.sck(sck_i), .mosi(mosi_i), .ss_n(rs_n), .cpol(1'b0), .cpha(1'b1), .tx_byte(rm_tx),
		.miso(rm_miso), .rx_byte(rm_rx));
	// Clock, plus edge and high-time counters of the serial clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	always @(negedge clk) if (sck_i) hi++;
	always @(posedge sck_i) ne++;
	task automatic complete_run();
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : complete_run
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		checked++;
		if (g !== e) begin
			failures++;
			$display("MISMATCH %0t got %h want %h", $time, g, e);
		end
	endtask : chk
	task automatic tmo();
		failures++;
		$display("MISMATCH %0t timeout", $time);
		complete_run();
	endtask : tmo
	// Write: address and data offered together, each dropped when taken
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		int k;
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h00_0000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (k = 0; k < 40; k++) begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		if (k == 40) tmo();
		rs = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge clk);
	endtask : wr
	task automatic rc(input logic [3:0] a, input logic [7:0] e);
		int k;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (k = 0; k < 40; k++) begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		if (k == 40) tmo();
		rs = s_axi_rresp;
		chk(s_axi_rdata[7:0], e);
		s_axi_rready <= 1'b0;
		@(posedge clk);
	endtask : rc
	// Master byte; waits on the edge count, since the flag may be set already
	task automatic xfer(input logic [7:0] rb, input logic [7:0] db);
		int k;
		rm_tx = rb;
		ne = 0;
		hi = 0;
		wr(da, db);
		for (k = 0; k < 3000 && ne < 8; k++) @(posedge clk);
		if (ne < 8) tmo();
		// Last trailing edge ends the byte; wait for the clock to return idle
		for (k = 0; k < 200 && sck_i; k++) @(posedge clk);
		if (sck_i) tmo();
		repeat (4) @(posedge clk);
	endtask : xfer
	// Far master, phase 1: half period of 8 clocks clears the synchronisers
	task automatic smx(input logic [7:0] d, input int nb);
		int k;
		ss_n_i <= 1'b0;
		repeat (8) @(posedge clk);
		for (k = 0; k < nb; k++) begin
			bm_sck <= 1'b1;
			bm_mosi <= d[7-k];
			repeat (8) @(posedge clk);
			bm_sck <= 1'b0;
			q = {q[6:0], miso_i};
			repeat (8) @(posedge clk);
		end
		chk(miso_oe, 1'b1);
		ss_n_i <= 1'b1;
		repeat (8) @(posedge clk);
	endtask : smx
	// Main sequence
	initial begin
		{rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h3F;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hF;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{ss_n_i, rs_n, bm_sck, bm_mosi, rm_tx, failures, checked} = '0;
		ss_n_i = 1'b1;
		rs_n = 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		for (i = 0; i < 10; i++) begin
			if (rows[i].w) wr(rows[i].a, rows[i].d);
			else rc(rows[i].a, rows[i].e);
			chk(rs, rows[i].r);
		end
		wr(ca, 8'h04);
		chk(pullup_en, 1'b0);
		wr(ca, 8'h00);
		chk(pullup_en, 1'b1);
		chk(ss_gpio, 1'b1);
		$display("registers done");
		rs_n <= 1'b0;
		for (i = 0; i < 4; i++) begin
			wr(sa, i[7:0]);
			wr(ca, 8'h2A);
			chk(sck_oe, 1'b1);
			xfer(8'h3C + i[7:0], 8'hA5 ^ i[7:0]);
			chk(ne, 8);
			chk(hi, 8 << (2 * i));
			rc(sa, 8'h88 | i[7:0]);
			rc(da, 8'h3C + i[7:0]);
			chk(rm_rx, 8'hA5 ^ i[7:0]);
			rc(sa, 8'h08 | i[7:0]);
		end
		$display("master done");
		wr(sa, 8'h40);
		xfer(8'h11, 8'h22);
		xfer(8'h33, 8'h44);
		chk(rx_irq, 1'b1);
		rc(sa, 8'hE8);
		rc(da, 8'h11);
		rc(sa, 8'h48);
		wr(ca, 8'h2B);
		chk(tx_irq, 1'b1);
		$display("overflow done");
		wr(sa, 8'h04);
		chk(ss_gpio, 1'b0);
		ss_n_i <= 1'b0;
		repeat (4) @(posedge clk);
		ss_n_i <= 1'b1;
		repeat (4) @(posedge clk);
		rc(ca, 8'h09);
		rc(sa, 8'h1C);
		wr(sa, 8'h00);
		rc(sa, 8'h18);
		wr(ca, 8'h00);
		rc(sa, 8'h08);
		$display("fault done");
		rs_n <= 1'b1;
		wr(sa, 8'h04);
		wr(ca, 8'h0A);
		chk(ss_gpio, 1'b0);
		chk(sck_oe, 1'b0);
		wr(da, 8'h96);
		smx(8'h69, 8);
		chk(q, 8'h96);
		chk(miso_oe, 1'b0);
		rc(sa, 8'h8C);
		rc(da, 8'h69);
		wr(da, 8'h5A);
		smx(8'hFF, 3);
		rc(sa, 8'h1C);
		$display("slave done");
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rc(ca, 8'h28);
		rc(sa, 8'h08);
		$display("reset done");
		complete_run();
	end
endmodule : spc_top_bench
`default_nettype wire
